/* File: ise_pkg.sv */
// Constants and types shared by the instruction subset execution unit
package ise_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W   = 11;
	localparam int ADDR_W = 8;

	localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST     = 11'h000;
	localparam logic [PC_W-1:0]   IRQ_VECTOR = 11'h004;
	localparam logic [PC_W-1:0]   PC_STEP    = 11'h001;
	localparam logic [DATA_W-1:0] INC_STEP   = 8'h01;

	typedef enum logic [3:0] {
		ISE_IDLE_INSTRUCTION,
		ISE_INCREMENT_TO_ACC,
		ISE_UNCONDITIONAL_BRANCH,
		ISE_COPY_MEM_TO_ACC,
		ISE_COPY_LIT_TO_ACC,
		ISE_COPY_ACC_TO_MEM,
		ISE_OR_MEM_TO_ACC,
		ISE_OR_LIT_TO_ACC,
		ISE_DISJUNCTION_TO_RAM,
		ISE_SUBROUTINE_EXIT,
		ISE_RETURN_LITERAL,
		ISE_INTERRUPT_EXIT
	} ise_op_t;

	// One decoded instruction as presented by the fetch path
	typedef struct packed {
		ise_op_t           op;
		logic [ADDR_W-1:0] mem_addr;
		logic [DATA_W-1:0] literal;
		logic [PC_W-1:0]   target;
	} ise_instr_t;

	// Data memory write request
	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ise_mem_wr_t;
endpackage

/* File: ise_exec.sv */
// Execution unit for the instruction subset: accumulator, flag, counter, stack
`timescale 1ns/1ps
module ise_exec #(
	parameter int STACK_DEPTH = 4
) (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rst_b,
	// Instruction fetch
	input  wire logic                       instr_valid,
	input  wire ise_pkg::ise_instr_t        instr,
	output logic                            instr_ready,
	output logic [ise_pkg::PC_W-1:0]        pc,
	// Data memory
	output logic [ise_pkg::ADDR_W-1:0]      mem_raddr,
	input  wire logic [ise_pkg::DATA_W-1:0] mem_rdata,
	output ise_pkg::ise_mem_wr_t            mem_wr,
	// Return address push from the call path
	input  wire logic                       push_valid,
	input  wire logic [ise_pkg::PC_W-1:0]   push_pc,
	// Interrupts
	input  wire logic                       irq_pending,
	output logic                            irq_taken,
	// Visible state
	output logic [ise_pkg::DATA_W-1:0]      acc,
	output logic                            zero_flag,
	output logic                            global_interrupt_enable
);
	import ise_pkg::*;

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rst_meta_b;
	logic rst_sync_b;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	typedef enum logic [1:0] {
		ISE_ST_EXEC,
		ISE_ST_FLUSH
	} ise_state_t;

	localparam int SP_W  = $clog2(STACK_DEPTH + 1);
	localparam int IDX_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

	ise_state_t           state;
	logic [PC_W-1:0]      stack_mem [STACK_DEPTH];
	logic [SP_W-1:0]      sp;
	logic [DATA_W-1:0]    next_acc;
	logic                 next_zero;
	logic                 exec;
	logic                 is_return;
	logic                 take_irq;
	logic [PC_W-1:0]      top_pc;
	logic                 push_en;
	logic                 pop_en;
	logic [PC_W-1:0]      push_data;

	function automatic logic zero_of(input logic [DATA_W-1:0] v);
		return v == '0;
	endfunction

	// A full stack keeps its depth; the newest entry replaces the top one
	function automatic logic is_full(input logic [SP_W-1:0] p);
		return p == SP_W'(STACK_DEPTH);
	endfunction

	function automatic logic [IDX_W-1:0] slot_of(input logic [SP_W-1:0] p);
		return is_full(p) ? IDX_W'(STACK_DEPTH - 1) : IDX_W'(p);
	endfunction

	assign instr_ready = (state == ISE_ST_EXEC) && !take_irq;
	assign exec        = instr_valid && instr_ready;
	assign is_return   = instr.op == ISE_SUBROUTINE_EXIT || instr.op == ISE_RETURN_LITERAL
	                     || instr.op == ISE_INTERRUPT_EXIT;
	assign top_pc      = (sp != '0) ? stack_mem[IDX_W'(sp - 1'b1)] : PC_RST;
	// Only taken between instructions, and only while enabled
	assign take_irq    = irq_pending && global_interrupt_enable
	                     && state == ISE_ST_EXEC;
	assign irq_taken   = take_irq;
	assign mem_raddr   = instr.mem_addr;

	// Branches and returns spend one dummy cycle while the counter reloads
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state <= ISE_ST_EXEC;
		end else begin
			case (state)
				ISE_ST_EXEC: begin
					if (take_irq || (exec && (instr.op == ISE_UNCONDITIONAL_BRANCH
					    || is_return))) begin
						state <= ISE_ST_FLUSH;
					end
				end
				ISE_ST_FLUSH: state <= ISE_ST_EXEC;
				default:      state <= ISE_ST_EXEC;
			endcase
		end
	end

	// ----------------------------------------
	// Program counter
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pc <= PC_RST;
		end else if (take_irq) begin
			// Interrupt exit re-enables first, so a pending one enters here
			// before the interrupted code resumes
			pc <= IRQ_VECTOR;
		end else if (exec) begin
			case (instr.op)
				ISE_UNCONDITIONAL_BRANCH: pc <= instr.target;
				ISE_SUBROUTINE_EXIT, ISE_RETURN_LITERAL, ISE_INTERRUPT_EXIT: begin
					pc <= top_pc;
				end
				default: pc <= PC_W'(pc + PC_STEP);
			endcase
		end
	end

	// ----------------------------------------
	// Return stack
	// ----------------------------------------
	// Interrupt entry pushes the counter; a call push is taken only in a ready cycle with no instruction, and is not held otherwise
	assign push_en   = take_irq || (push_valid && instr_ready && !exec);
	assign pop_en    = exec && is_return;
	assign push_data = take_irq ? pc : push_pc;

	// Entries carry no reset value; only the pointer says what is live
	always_ff @(posedge core_clk) begin
		if (push_en) begin
			stack_mem[slot_of(sp)] <= push_data;
		end
	end

	// Shallow stack: overflow overwrites the top entry, underflow stays empty
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sp <= '0;
		end else if (push_en) begin
			if (!is_full(sp)) sp <= SP_W'(sp + 1'b1);
		end else if (pop_en) begin
			if (sp != '0) sp <= SP_W'(sp - 1'b1);
		end
	end

	// ----------------------------------------
	// Accumulator and zero flag
	// ----------------------------------------
	always_comb begin
		next_acc  = acc;
		next_zero = zero_flag;
		case (instr.op)
			ISE_INCREMENT_TO_ACC: begin
				next_acc  = DATA_W'(mem_rdata + INC_STEP);
				next_zero = zero_of(next_acc);
			end
			ISE_COPY_MEM_TO_ACC: next_acc = mem_rdata;
			ISE_COPY_LIT_TO_ACC: next_acc = instr.literal;
			ISE_OR_MEM_TO_ACC: begin
				next_acc  = acc | mem_rdata;
				next_zero = zero_of(next_acc);
			end
			ISE_OR_LIT_TO_ACC: begin
				next_acc  = acc | instr.literal;
				next_zero = zero_of(next_acc);
			end
			ISE_DISJUNCTION_TO_RAM: next_zero = zero_of(acc | mem_rdata);
			ISE_RETURN_LITERAL:     next_acc  = instr.literal;
			default: begin
				next_acc  = acc;
				next_zero = zero_flag;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			acc       <= ACC_RST;
			zero_flag <= 1'b0;
		end else if (exec) begin
			acc       <= next_acc;
			zero_flag <= next_zero;
		end
	end

	// ----------------------------------------
	// Data memory writes
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mem_wr <= '0;
		end else begin
			mem_wr.we   <= exec && (instr.op == ISE_COPY_ACC_TO_MEM
			               || instr.op == ISE_DISJUNCTION_TO_RAM);
			mem_wr.addr <= instr.mem_addr;
			mem_wr.data <= (instr.op == ISE_DISJUNCTION_TO_RAM) ? (acc | mem_rdata)
			               : acc;
		end
	end

	// ----------------------------------------
	// Global interrupt enable
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			global_interrupt_enable <= 1'b0;
		end else if (take_irq) begin
			global_interrupt_enable <= 1'b0;
		end else if (exec && instr.op == ISE_INTERRUPT_EXIT) begin
			global_interrupt_enable <= 1'b1;
		end
	end
endmodule

/* File: ise_exec_properties.sv */
// Port-level checks on the instruction subset execution unit
`timescale 1ns/1ps
module ise_exec_properties #(
	parameter int STACK_DEPTH = 4
) (
	// Clock and reset
	input wire logic                       core_clk,
	input wire logic                       rst_b,
	// Instruction fetch
	input wire logic                       instr_valid,
	input wire ise_pkg::ise_instr_t        instr,
	input wire logic                       instr_ready,
	input wire logic [ise_pkg::PC_W-1:0]   pc,
	// Data memory
	input wire logic [ise_pkg::ADDR_W-1:0] mem_raddr,
	input wire logic [ise_pkg::DATA_W-1:0] mem_rdata,
	input wire ise_pkg::ise_mem_wr_t       mem_wr,
	// Return address push
	input wire logic                       push_valid,
	input wire logic [ise_pkg::PC_W-1:0]   push_pc,
	// Interrupts
	input wire logic                       irq_pending,
	input wire logic                       irq_taken,
	// Visible state
	input wire logic [ise_pkg::DATA_W-1:0] acc,
	input wire logic                       zero_flag,
	input wire logic                       global_interrupt_enable
);
	import ise_pkg::*;
	logic    go;
	ise_op_t op;
	assign go = instr_valid && instr_ready;
	assign op = instr.op;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	inc_acc_a: assert property (go && op == ISE_INCREMENT_TO_ACC |=>
		acc == $past(mem_rdata) + 8'h01 && zero_flag == (acc == 8'h00) && !mem_wr.we)
		else $error("increment result wrong");
	jump_pc_a: assert property (go && op == ISE_UNCONDITIONAL_BRANCH |=>
		pc == $past(instr.target) && $stable(zero_flag)) else $error("jump target wrong");
	flush_gap_a: assert property (go && op inside {ISE_UNCONDITIONAL_BRANCH,
		ISE_SUBROUTINE_EXIT, ISE_RETURN_LITERAL, ISE_INTERRUPT_EXIT} |=> !instr_ready)
		else $error("no dead cycle");
	load_mem_a: assert property (go && op == ISE_COPY_MEM_TO_ACC |=>
		acc == $past(mem_rdata) && $stable(zero_flag)) else $error("memory load wrong");
	load_lit_a: assert property (go && op inside {ISE_COPY_LIT_TO_ACC,
		ISE_RETURN_LITERAL} |=> acc == $past(instr.literal) && $stable(zero_flag))
		else $error("literal load wrong");
	store_acc_a: assert property (go && op == ISE_COPY_ACC_TO_MEM |=> mem_wr.we &&
		mem_wr.addr == $past(instr.mem_addr) && mem_wr.data == $past(acc))
		else $error("store wrong");
	or_mem_a: assert property (go && op == ISE_OR_MEM_TO_ACC |=>
		acc == ($past(acc) | $past(mem_rdata)) && zero_flag == (acc == 8'h00))
		else $error("or memory wrong");
	or_lit_a: assert property (go && op == ISE_OR_LIT_TO_ACC |=>
		acc == ($past(acc) | $past(instr.literal)) && zero_flag == (acc == 8'h00))
		else $error("or literal wrong");
	or_ram_a: assert property (go && op == ISE_DISJUNCTION_TO_RAM |=> mem_wr.we &&
		mem_wr.data == ($past(acc) | $past(mem_rdata)) && zero_flag == (mem_wr.data == 8'h00))
		else $error("or to memory wrong");
	idle_op_a: assert property (go && op == ISE_IDLE_INSTRUCTION |=>
		pc == $past(pc) + PC_STEP && $stable(acc) && $stable(zero_flag) && !mem_wr.we)
		else $error("idle changed state");
	irq_exit_a: assert property (go && op == ISE_INTERRUPT_EXIT |=>
		global_interrupt_enable) else $error("enable not set");
	irq_gate_a: assert property (irq_taken |->
		global_interrupt_enable && irq_pending) else $error("irq taken while masked");
	irq_first_a: assert property ((go && op == ISE_INTERRUPT_EXIT) ##2 irq_pending
		|-> irq_taken) else $error("pending irq not served");
	irq_entry_a: assert property (irq_taken |=> pc == IRQ_VECTOR
		&& !global_interrupt_enable && !instr_ready) else $error("irq entry wrong");
	read_addr_a: assert property (go && op inside {ISE_INCREMENT_TO_ACC,
		ISE_COPY_MEM_TO_ACC, ISE_OR_MEM_TO_ACC, ISE_DISJUNCTION_TO_RAM}
		|-> mem_raddr == instr.mem_addr) else $error("read address wrong");
	ret_flags_a: assert property (go && op inside {ISE_SUBROUTINE_EXIT,
		ISE_INTERRUPT_EXIT} |=> $stable(acc) && $stable(zero_flag))
		else $error("return changed flags");
	push_pop_a: assert property ((push_valid && instr_ready && !instr_valid)
		##1 (!push_valid && !instr_valid) ##1 (go && op inside {ISE_SUBROUTINE_EXIT,
		ISE_RETURN_LITERAL, ISE_INTERRUPT_EXIT}) |=> pc == $past(push_pc, 3))
		else $error("pushed address not returned");
endmodule

bind ise_exec ise_exec_properties #(.STACK_DEPTH(STACK_DEPTH)) chk_u (.core_clk, .rst_b,
	.instr_valid, .instr_ready, .instr, .pc, .push_pc, .mem_raddr, .mem_rdata, .acc, .mem_wr,
	.push_valid, .irq_pending, .irq_taken, .zero_flag, .global_interrupt_enable);

/* File: tb_mcu_instruction_subset_exec.sv */
// Self-checking bench for the instruction subset execution unit
`timescale 1ns/1ps
`define CK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb_mcu_instruction_subset_exec;
	import ise_pkg::*;
	logic            core_clk, rst_b, instr_valid, instr_ready, push_valid;
	logic            irq_pending, irq_taken, zero_flag, global_interrupt_enable;
	ise_instr_t      instr;
	ise_mem_wr_t     mem_wr;
	logic [PC_W-1:0] pc, push_pc, ep;
	logic [7:0]      mem_raddr, mem_rdata, acc;
	int              mismatches, cmp_count, i;
	ise_exec dut_u (.core_clk, .rst_b, .instr_valid, .instr, .instr_ready, .pc, .mem_raddr,
		.mem_rdata, .mem_wr, .push_valid, .push_pc, .irq_pending, .irq_taken, .acc,
		.zero_flag, .global_interrupt_enable);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One instruction; valid dropped after it is taken so it never repeats
	task automatic run_op(ise_op_t o, logic [7:0] l, logic [7:0] d, logic [PC_W-1:0] t);
		logic j;
		j = o inside {ISE_UNCONDITIONAL_BRANCH, ISE_SUBROUTINE_EXIT, ISE_RETURN_LITERAL,
			ISE_INTERRUPT_EXIT};
		@(negedge core_clk);
		instr = '{o, l, l, t};
		mem_rdata = d;
		instr_valid = 1'b1;
		for (i = 0; i < 8 && !instr_ready; i++) @(negedge core_clk);
		@(negedge core_clk);
		instr_valid = 1'b0;
		`CK(mem_raddr, l)
		ep = j ? t : ep + PC_STEP;
		`CK(pc, ep)
		if (j) `CK(instr_ready, 1'b0)
	endtask
	task automatic push(logic [PC_W-1:0] p);
		@(negedge core_clk);
		push_valid = 1'b1;
		push_pc = p;
		@(negedge core_clk);
		push_valid = 1'b0;
	endtask
	task automatic data_ops;
		run_op(ISE_COPY_LIT_TO_ACC, 8'h00, 8'h00, '0);
		run_op(ISE_OR_LIT_TO_ACC, 8'h00, 8'h00, '0);
		`CK(zero_flag, 1'b1)
		run_op(ISE_OR_LIT_TO_ACC, 8'h81, 8'h00, '0);
		`CK(acc, 8'h81)
		run_op(ISE_COPY_LIT_TO_ACC, 8'h00, 8'h00, '0);
		`CK(zero_flag, 1'b0)
		run_op(ISE_INCREMENT_TO_ACC, 8'h20, 8'hff, '0);
		`CK({acc, zero_flag, mem_wr.we}, 10'h002)
		run_op(ISE_COPY_MEM_TO_ACC, 8'h10, 8'h5a, '0);
		`CK({acc, zero_flag}, 9'h0b5)
		run_op(ISE_OR_MEM_TO_ACC, 8'h30, 8'h24, '0);
		`CK({acc, zero_flag}, 9'h0fc)
		run_op(ISE_COPY_ACC_TO_MEM, 8'h7f, 8'h00, '0);
		`CK(mem_wr, ise_mem_wr_t'({1'b1, 8'h7f, 8'h7e}))
		run_op(ISE_DISJUNCTION_TO_RAM, 8'h40, 8'h81, '0);
		`CK({mem_wr, zero_flag}, 18'h281fe)
		run_op(ISE_IDLE_INSTRUCTION, 8'h00, 8'h00, '0);
		`CK({acc, mem_wr.we}, 9'h0fc)
	endtask
	task automatic flow_ops;
		run_op(ISE_UNCONDITIONAL_BRANCH, 8'h00, 8'h00, 11'h555);
		push(11'h123);
		push(11'h2aa);
		run_op(ISE_SUBROUTINE_EXIT, 8'h00, 8'h00, 11'h2aa);
		run_op(ISE_RETURN_LITERAL, 8'h00, 8'h00, 11'h123);
		`CK({acc, zero_flag}, 9'h000)
	endtask
	task automatic irq_ops;
		@(negedge core_clk);
		irq_pending = 1'b1;
		@(negedge core_clk);
		`CK(irq_taken, 1'b0)
		push(11'h0aa);
		run_op(ISE_INTERRUPT_EXIT, 8'h00, 8'h00, 11'h0aa);
		`CK(global_interrupt_enable, 1'b1)
		@(negedge core_clk);
		`CK(irq_taken, 1'b1)
		@(negedge core_clk);
		irq_pending = 1'b0;
		`CK({pc, global_interrupt_enable}, {IRQ_VECTOR, 1'b0})
	endtask
	initial begin
		rst_b = 1'b0;
		instr_valid = 1'b0;
		instr = '0;
		mem_rdata = 8'h00;
		push_valid = 1'b0;
		push_pc = '0;
		irq_pending = 1'b0;
		ep = PC_RST;
		repeat (8) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge core_clk);
		data_ops;
		flow_ops;
		irq_ops;
		wrap_up;
	end
	// Whole run is under 100 cycles
	initial begin
		#20000;
		mismatches++;
		wrap_up;
	end
endmodule
